// ===== core/pshoc_pkg.sv
// ==========================================================================
package pshoc_pkg;
   // ==========================================================================
   // Frame layout and codes
   localparam int FRAME_BYTES = 9;
   localparam logic [7:0] INSTR_STORE = 8'h0B;
   localparam logic [7:0] INSTR_RESTORE = 8'h0C;
   localparam logic [7:0] INSTR_HOME = 8'h0D;
   localparam logic [7:0] INSTR_SETOUT = 8'h0E;
   localparam logic [7:0] BANK_GLOBAL = 8'h00;
   localparam logic [7:0] BANK_USER = 8'h02;
   localparam logic [7:0] HOME_START = 8'h00;
   localparam logic [7:0] HOME_STOP = 8'h01;
   localparam logic [7:0] HOME_STATUS = 8'h02;
   localparam logic [7:0] PORT_ALL = 8'hFF;
   localparam logic [31:0] VALUE_FROM_ACC = 32'hFFFFFFFF;
   localparam logic [7:0] ST_OK = 8'h64;
   localparam logic [7:0] ST_BAD_CHECKSUM = 8'h01;
   localparam logic [7:0] ST_BAD_COMMAND = 8'h02;
   localparam logic [7:0] ST_BAD_TYPE = 8'h03;
   localparam logic [7:0] ST_BAD_VALUE = 8'h04;
   localparam logic [7:0] HOST_ADDR = 8'h02;
   localparam logic [31:0] HOME_ACTIVE_VALUE = 32'h00000001;
   localparam int AXES = 6;
   localparam int OUTPUTS = 4;
   localparam int USER_VARS = 256;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] instr;
      logic [7:0] ctype;
      logic [7:0] bank;
      logic [31:0] value;
   } pshoc_cmd_type;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] instr;
      logic [31:0] value;
   } pshoc_reply_type;

   typedef struct packed {
      logic wr;
      logic [7:0] index;
      logic [31:0] data;
   } pshoc_nvm_req_type;
endpackage

// ===== core/pshoc_core.sv
`timescale 1ns/1ps
module pshoc_core #(
   parameter logic [7:0] MODULE_ADDR = 8'h01,
   parameter bit AUTO_RESTORE = 1'b1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Incoming frame bytes
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   // Reply frame bytes
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   // User variable access from the rest of the module
   input wire logic uv_wr,
   input wire logic [7:0] uv_index,
   input wire logic [31:0] uv_wdata,
   output logic [31:0] uv_rdata,
   // Global bank 0 change notice
   input wire logic global_wr,
   input wire logic [7:0] global_index,
   input wire logic [31:0] global_wdata,
   // Accumulator of the program engine
   input wire logic [31:0] accumulator,
   // Nonvolatile store port
   output pshoc_pkg::pshoc_nvm_req_type nvm_req,
   output logic nvm_req_valid,
   input wire logic nvm_req_ready,
   output logic nvm_sel_global,
   input wire logic nvm_rvalid,
   input wire logic [31:0] nvm_rdata,
   // Homing engines
   output logic [5:0] home_start,
   output logic [5:0] home_stop,
   input wire logic [5:0] home_busy,
   // Outputs and status
   output logic [3:0] general_output_line,
   output logic boot_busy
);
   import pshoc_pkg::*;

   // Gray steps along boot, receive, execute, store and reply
   typedef enum logic [2:0] {
      S_BOOT_REQ = 3'b000,
      S_BOOT_WAIT = 3'b001,
      S_RX = 3'b011,
      S_EXEC = 3'b010,
      S_NVM_REQ = 3'b110,
      S_NVM_WAIT = 3'b111,
      S_TX = 3'b101
   } pshoc_state_type;

   function automatic logic [7:0] sum8(input logic [7:0] a, input logic [7:0] b);
      sum8 = 8'(a + b);
   endfunction

   pshoc_state_type state_q;
   logic [3:0] cnt_q;
   logic [7:0] sum_q;
   pshoc_cmd_type cmd_q;
   pshoc_reply_type reply_q;
   logic [7:0] tx_sum_q;
   logic [8:0] boot_idx_q;
   logic [31:0] uvar_q [USER_VARS];
   logic [5:0] home_sync1_q;
   logic [5:0] home_busy_q;
   logic global_pend_q;
   logic [7:0] global_idx_q;
   logic [31:0] global_data_q;
   logic cmd_is_store;
   logic [3:0] out_vec;

   // ==========================================================================
   // Frame receive and checksum
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         cnt_q <= 4'h0;
         sum_q <= 8'h00;
         cmd_q <= '0;
      end
      else if (state_q == S_RX && rx_valid)
      begin
         case (cnt_q)
            4'h0: cmd_q.addr <= rx_byte;
            4'h1: cmd_q.instr <= rx_byte;
            4'h2: cmd_q.ctype <= rx_byte;
            4'h3: cmd_q.bank <= rx_byte;
            4'h8: ;
            default: cmd_q.value <= {cmd_q.value[23:0], rx_byte};
         endcase
         // The checksum byte is compared, not summed; clearing readies the next frame
         sum_q <= (cnt_q == 4'h8) ? 8'h00 : sum8(sum_q, rx_byte);
         cnt_q <= (cnt_q == 4'(FRAME_BYTES - 1)) ? 4'h0 : 4'(cnt_q + 4'h1);
      end
      else if (state_q == S_TX && tx_ready && cnt_q == 4'(FRAME_BYTES - 1))
         cnt_q <= 4'h0;
      else if (state_q == S_TX && tx_ready)
         cnt_q <= 4'(cnt_q + 4'h1);
   end

   // Synchronise the homing engines' busy flags
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         home_sync1_q <= 6'h00;
         home_busy_q <= 6'h00;
      end
      else
      begin
         home_sync1_q <= home_busy;
         home_busy_q <= home_sync1_q;
      end
   end

   // All-ones value on the all-outputs port means take the bits from the accumulator
   assign cmd_is_store = (cmd_q.instr == INSTR_STORE);
   assign out_vec = (cmd_q.value == VALUE_FROM_ACC) ? accumulator[3:0] : cmd_q.value[3:0];

   // ==========================================================================
   // Command sequencer
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state_q <= AUTO_RESTORE ? S_BOOT_REQ : S_RX;
         boot_idx_q <= 9'h000;
         reply_q <= '0;
         home_start <= 6'h00;
         home_stop <= 6'h00;
         general_output_line <= 4'h0;
      end
      else
      begin
         home_start <= 6'h00;
         home_stop <= 6'h00;
         case (state_q)
            // A waiting bank 0 commit owns the store port first
            S_BOOT_REQ:
               if (global_pend_q)
                  state_q <= S_BOOT_REQ;
               else if (nvm_req_ready)
                  state_q <= S_BOOT_WAIT;

            S_BOOT_WAIT:
               if (nvm_rvalid)
               begin
                  boot_idx_q <= 9'(boot_idx_q + 9'h001);
                  state_q <= (boot_idx_q == 9'(USER_VARS - 1)) ? S_RX : S_BOOT_REQ;
               end

            // Frames for another address are dropped without a reply unless their checksum is bad
            S_RX:
               if (rx_valid && cnt_q == 4'(FRAME_BYTES - 1))
               begin
                  state_q <= S_EXEC;
                  reply_q <= '{ST_OK, cmd_q.instr, 32'h00000000};
                  if (sum_q != rx_byte)
                     reply_q.status <= ST_BAD_CHECKSUM;
                  else if (cmd_q.addr != MODULE_ADDR)
                     state_q <= S_RX;
               end

            S_EXEC:
            begin
               state_q <= S_TX;
               if (reply_q.status == ST_OK)
                  case (cmd_q.instr)
                     INSTR_STORE, INSTR_RESTORE:
                        if (cmd_q.bank != BANK_USER)
                           reply_q.status <= ST_BAD_VALUE;
                        else
                           state_q <= S_NVM_REQ;
                     INSTR_HOME:
                        if (cmd_q.bank >= 8'(AXES))
                           reply_q.status <= ST_BAD_VALUE;
                        else if (cmd_q.ctype == HOME_START)
                           home_start[cmd_q.bank[2:0]] <= 1'b1;
                        else if (cmd_q.ctype == HOME_STOP)
                           home_stop[cmd_q.bank[2:0]] <= 1'b1;
                        else if (cmd_q.ctype == HOME_STATUS)
                           reply_q.value <= home_busy_q[cmd_q.bank[2:0]] ? HOME_ACTIVE_VALUE : 32'h00000000;
                        else
                           reply_q.status <= ST_BAD_TYPE;
                     INSTR_SETOUT:
                        if (cmd_q.bank != BANK_USER)
                           reply_q.status <= ST_BAD_VALUE;
                        else if (cmd_q.ctype == PORT_ALL)
                           general_output_line <= out_vec;
                        else if (cmd_q.ctype < 8'(OUTPUTS) && cmd_q.value[31:1] == 31'h00000000)
                           general_output_line[cmd_q.ctype[1:0]] <= cmd_q.value[0];
                        else if (cmd_q.ctype < 8'(OUTPUTS))
                           reply_q.status <= ST_BAD_VALUE;
                        else
                           reply_q.status <= ST_BAD_TYPE;
                     default:
                        reply_q.status <= ST_BAD_COMMAND;
                  endcase
            end

            // Stores reply once the write is taken; restores wait for the data
            S_NVM_REQ:
               if (nvm_req_ready && !global_pend_q)
                  state_q <= cmd_is_store ? S_TX : S_NVM_WAIT;

            S_NVM_WAIT:
               if (nvm_rvalid)
                  state_q <= S_TX;

            S_TX:
               if (tx_ready && cnt_q == 4'(FRAME_BYTES - 1))
                  state_q <= S_RX;

            default:
               state_q <= S_RX;
         endcase
      end
   end

   // ==========================================================================
   // User variables; restore and boot reload win over a change in the same cycle
   // The array has no reset so it can sit in block memory; boot reload fills it
   always_ff @(posedge mclk)
   begin
      if (nvm_rvalid && state_q == S_BOOT_WAIT)
         uvar_q[boot_idx_q[7:0]] <= nvm_rdata;
      else if (nvm_rvalid && state_q == S_NVM_WAIT)
         uvar_q[cmd_q.ctype] <= nvm_rdata;
      else if (uv_wr)
         uvar_q[uv_index] <= uv_wdata;
   end

   assign uv_rdata = uvar_q[uv_index];

   // Bank 0 changes are held until the store port takes them; a newer change overwrites a waiting one
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         global_pend_q <= 1'b0;
         global_idx_q <= 8'h00;
         global_data_q <= 32'h00000000;
      end
      else if (global_wr)
      begin
         global_pend_q <= 1'b1;
         global_idx_q <= global_index;
         global_data_q <= global_wdata;
      end
      else if (nvm_req_ready)
         global_pend_q <= 1'b0;
   end

   // ==========================================================================
   // Store port: pending bank 0 commit has priority over user variable traffic
   always_comb
   begin
      nvm_sel_global = global_pend_q;
      nvm_req_valid = global_pend_q || state_q == S_BOOT_REQ || state_q == S_NVM_REQ;
      if (global_pend_q)
         nvm_req = '{1'b1, global_idx_q, global_data_q};
      else if (state_q == S_BOOT_REQ)
         nvm_req = '{1'b0, boot_idx_q[7:0], 32'h00000000};
      else
         nvm_req = '{cmd_is_store, cmd_q.ctype, uvar_q[cmd_q.ctype]};
   end

   assign boot_busy = (state_q == S_BOOT_REQ || state_q == S_BOOT_WAIT);

   // ==========================================================================
   // Reply: host, module, status, instruction, value msb first, checksum
   // Running sum covers only bytes the sink has already accepted
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         tx_sum_q <= 8'h00;
      else if (state_q != S_TX)
         tx_sum_q <= 8'h00;
      else if (tx_ready)
         tx_sum_q <= sum8(tx_sum_q, tx_byte);
   end

   always_comb
   begin
      tx_valid = (state_q == S_TX);
      case (cnt_q)
         4'h0: tx_byte = HOST_ADDR;
         4'h1: tx_byte = MODULE_ADDR;
         4'h2: tx_byte = reply_q.status;
         4'h3: tx_byte = reply_q.instr;
         4'h4: tx_byte = reply_q.value[31:24];
         4'h5: tx_byte = reply_q.value[23:16];
         4'h6: tx_byte = reply_q.value[15:8];
         4'h7: tx_byte = reply_q.value[7:0];
         default: tx_byte = tx_sum_q;
      endcase
   end
endmodule // pshoc_core

// ===== verification/pshoc_core_monitor.sv
`timescale 1ns/1ps
module pshoc_core_monitor (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Watched ports
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_ready,
   input wire logic global_wr,
   input wire pshoc_pkg::pshoc_nvm_req_type nvm_req,
   input wire logic nvm_req_valid,
   input wire logic nvm_req_ready,
   input wire logic nvm_sel_global,
   input wire logic [5:0] home_start,
   input wire logic [5:0] home_stop,
   input wire logic [3:0] general_output_line,
   input wire logic boot_busy
);
   import pshoc_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ==========
   // Checks
   one_axis_a: assert property ($onehot0(home_start) && $onehot0(home_stop))
      else $error("more than one axis pulsed");
   start_stop_a: assert property ((home_start & home_stop) == 6'h00)
      else $error("start and stop together");
   pulse_width_a: assert property (|home_start |=> home_start == 6'h00)
      else $error("start pulse too long");
   global_commit_a: assert property (global_wr && !boot_busy |-> ##[0:40] (nvm_req_valid && nvm_sel_global && nvm_req.wr))
      else $error("global change not committed");
   boot_read_a: assert property (boot_busy && nvm_req_valid && !nvm_sel_global |-> !nvm_req.wr)
      else $error("boot reload issued a write");
   out_change_a: assert property ($changed(general_output_line) |-> $rose(tx_valid))
      else $error("outputs moved outside a command");
   reply_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("reply byte dropped while stalled");
   reply_head_a: assert property ($rose(tx_valid) |-> tx_byte == HOST_ADDR)
      else $error("reply does not start with host address");
   nvm_hold_a: assert property (nvm_req_valid && !nvm_req_ready && !global_wr |=> nvm_req_valid && $stable(nvm_req))
      else $error("store request changed while waiting");
endmodule // pshoc_core_monitor

// ===== verification/pshoc_nvm_model.sv
`timescale 1ns/1ps
module pshoc_nvm_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Store port
   input wire pshoc_pkg::pshoc_nvm_req_type nvm_req,
   input wire logic nvm_req_valid,
   output logic nvm_req_ready,
   input wire logic nvm_sel_global,
   output logic nvm_rvalid,
   output logic [31:0] nvm_rdata,
   // Stall every request by one cycle
   input wire logic slow
);
   import pshoc_pkg::*;
   logic [31:0] umem [256];
   logic [31:0] gmem [256];
   logic wait_q;
   // ==========
   // Stored image
   initial for (int i = 0; i < 256; i++) umem[i] = 32'hC0DE0000 | 32'(i);
   assign nvm_req_ready = nvm_req_valid && !(slow && !wait_q);
   always @(posedge mclk)
   begin
      wait_q <= rst_n && nvm_req_valid && !nvm_req_ready;
      nvm_rvalid <= rst_n && nvm_req_valid && nvm_req_ready && !nvm_req.wr;
      if (nvm_req_valid && nvm_req_ready && nvm_req.wr && nvm_sel_global)
         gmem[nvm_req.index] <= nvm_req.data;
      if (nvm_req_valid && nvm_req_ready && nvm_req.wr && !nvm_sel_global)
         umem[nvm_req.index] <= nvm_req.data;
      // Outside a return the data lines toggle so a stale read cannot match
      if (!rst_n)
         nvm_rdata <= 32'h00000000;
      else if (nvm_req_valid && nvm_req_ready && !nvm_req.wr)
         nvm_rdata <= umem[nvm_req.index];
      else
         nvm_rdata <= ~nvm_rdata;
   end
endmodule // pshoc_nvm_model

// ===== verification/tb_pshoc_core.sv
`timescale 1ns/1ps
module tb_pshoc_core;
   import pshoc_pkg::*;
   logic mclk = 0, rst_n = 0, rx_valid = 0, tx_ready = 0, uv_wr = 0, global_wr = 0, slow = 0;
   logic [7:0] rx_byte = 0, uv_index = 0, global_index = 0, tx_byte;
   logic [31:0] uv_wdata = 0, global_wdata = 0, accumulator = 0, uv_rdata, nvm_rdata, rv;
   logic [5:0] home_busy = 0, home_start, home_stop;
   logic [3:0] general_output_line;
   logic tx_valid, nvm_req_valid, nvm_req_ready, nvm_sel_global, nvm_rvalid, boot_busy;
   pshoc_nvm_req_type nvm_req;
   logic [7:0] r [9];
   int bad_count = 0, checked = 0;
   logic [5:0] seen_start = 6'h00, seen_stop = 6'h00;
   assign rv = {r[4], r[5], r[6], r[7]};
   pshoc_core i_dut (.mclk, .rst_n, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready, .uv_wr, .uv_index,
      .uv_wdata, .uv_rdata, .global_wr, .global_index, .global_wdata, .accumulator, .nvm_req, .nvm_req_valid,
      .nvm_req_ready, .nvm_sel_global, .nvm_rvalid, .nvm_rdata, .home_start, .home_stop, .home_busy,
      .general_output_line, .boot_busy);
   pshoc_nvm_model i_nvm (.mclk, .rst_n, .nvm_req, .nvm_req_valid, .nvm_req_ready, .nvm_sel_global,
      .nvm_rvalid, .nvm_rdata, .slow);
   initial forever #4 mclk = ~mclk;
   // Sticky record of which axes were pulsed
   always @(posedge mclk)
   begin
      if (rst_n)
      begin
         seen_start <= seen_start | home_start;
         seen_stop <= seen_stop | home_stop;
      end
   end
   // ==========
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task automatic wrap_up();
   begin
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   // Sends one frame, then takes the reply after a one-cycle stall
   task automatic cmd(input logic [7:0] ins, typ, bnk, input logic [31:0] val, input logic [7:0] skew);
      logic [7:0] f [9];
      logic [7:0] s;
      int n;
      f = '{8'h01, ins, typ, bnk, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
      s = 8'h00;
      for (int i = 0; i < 8; i++) s += f[i];
      f[8] = s + skew;
      for (int i = 0; i < 9; i++)
      begin
         rx_valid = 1;
         rx_byte = f[i];
         @(posedge mclk);
         #1;
      end
      rx_valid = 0;
      n = 0;
      while (tx_valid !== 1'b1 && n < 600)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(tx_valid, 1'b1);
      @(posedge mclk);
      #1 tx_ready = 1;
      for (int i = 0; i < 9; i++)
      begin
         // Take the byte that stands before the edge that accepts it
         r[i] = tx_byte;
         @(posedge mclk);
         #1;
      end
      tx_ready = 0;
      s = 8'h00;
      for (int i = 0; i < 8; i++) s += r[i];
      chk(r[8], s);
      chk(r[0], HOST_ADDR);
      chk(r[1], 8'h01);
      chk(r[3], ins);
   endtask
   // ==========
   // Sequence
   initial
   begin
      int n;
      n = 0;
      uv_index = 8'h05;
      repeat (16) @(posedge mclk);
      #1 rst_n = 1;
      while (boot_busy !== 1'b0 && n < 3000)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(boot_busy, 1'b0);
      chk(uv_rdata, 32'hC0DE0005);
      for (int p = 0; p < 4; p++)
      begin
         cmd(INSTR_SETOUT, p[7:0], BANK_USER, 32'h1, 8'h00);
         chk(r[2], ST_OK);
         chk(general_output_line[p], 1'b1);
      end
      cmd(INSTR_SETOUT, 8'h02, BANK_USER, 32'h0, 8'h00);
      chk(general_output_line, 4'hB);
      cmd(INSTR_SETOUT, 8'h01, BANK_USER, 32'h2, 8'h00);
      chk(r[2], ST_BAD_VALUE);
      chk(general_output_line, 4'hB);
      cmd(INSTR_SETOUT, 8'h04, BANK_USER, 32'h1, 8'h00);
      chk(r[2], ST_BAD_TYPE);
      cmd(INSTR_SETOUT, PORT_ALL, BANK_USER, 32'h5, 8'h00);
      chk(general_output_line, 4'h5);
      accumulator = 32'hA;
      cmd(INSTR_SETOUT, PORT_ALL, BANK_USER, VALUE_FROM_ACC, 8'h00);
      chk(general_output_line, 4'hA);
      cmd(8'h00, 8'h00, BANK_USER, 32'h0, 8'h00);
      chk(r[2], ST_BAD_COMMAND);
      slow = 1;
      uv_wr = 1;
      uv_index = 8'h07;
      uv_wdata = 32'h1234;
      @(posedge mclk);
      #1 uv_wr = 0;
      cmd(INSTR_STORE, 8'h07, BANK_USER, 32'h0, 8'h00);
      chk(r[2], ST_OK);
      chk(i_nvm.umem[7], 32'h1234);
      cmd(INSTR_STORE, 8'h07, BANK_GLOBAL, 32'h0, 8'h00);
      chk(r[2], ST_BAD_VALUE);
      uv_wr = 1;
      uv_wdata = 32'h99;
      @(posedge mclk);
      #1 uv_wr = 0;
      chk(uv_rdata, 32'h99);
      cmd(INSTR_RESTORE, 8'h07, BANK_USER, 32'h0, 8'h00);
      chk(r[2], ST_OK);
      chk(uv_rdata, 32'h1234);
      slow = 0;
      global_wr = 1;
      global_index = 8'h03;
      global_wdata = 32'h55;
      @(posedge mclk);
      #1 global_wr = 0;
      repeat (8) @(posedge mclk);
      #1 chk(i_nvm.gmem[3], 32'h55);
      for (int a = 0; a < 6; a++)
      begin
         cmd(INSTR_HOME, HOME_START, a[7:0], 32'h0, 8'h00);
         chk(r[2], ST_OK);
         chk(seen_start, (32'h1 << (a + 1)) - 32'h1);
         chk(seen_stop, (32'h1 << a) - 32'h1);
         home_busy = 6'h01 << a;
         cmd(INSTR_HOME, HOME_STATUS, a[7:0], 32'h0, 8'h00);
         chk(r[2], ST_OK);
         chk(|rv, 1'b1);
         cmd(INSTR_HOME, HOME_STATUS, 8'((a + 1) % 6), 32'h0, 8'h00);
         chk(rv, 32'h0);
         home_busy = 6'h00;
         cmd(INSTR_HOME, HOME_STOP, a[7:0], 32'h0, 8'h00);
         chk(r[2], ST_OK);
         chk(seen_stop, (32'h1 << (a + 1)) - 32'h1);
      end
      cmd(INSTR_HOME, 8'h03, 8'h00, 32'h0, 8'h00);
      chk(r[2], ST_BAD_TYPE);
      cmd(INSTR_HOME, HOME_START, 8'h06, 32'h0, 8'h00);
      chk(r[2], ST_BAD_VALUE);
      chk(seen_start, 32'h3F);
      cmd(INSTR_SETOUT, 8'h01, BANK_USER, 32'h0, 8'h01);
      chk(r[2], ST_BAD_CHECKSUM);
      chk(general_output_line, 4'hA);
      wrap_up();
   end
   initial
   begin
      #400000;
      bad_count++;
      wrap_up();
   end
endmodule // tb_pshoc_core
bind pshoc_core pshoc_core_monitor i_mon (.mclk, .rst_n, .tx_valid, .tx_byte, .tx_ready, .global_wr, .nvm_req,
   .nvm_req_valid, .nvm_req_ready, .nvm_sel_global, .home_start, .home_stop, .general_output_line, .boot_busy);
